//--- core/pcx_crossbar.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// [RULE1] Each enabled resource, UART first, gets lowest free unskipped pin; the UART here takes fixed pins 0.4 and 0.5, skip bits ignored.
// [RULE2] A granted pin is passed over for every later resource.
// [RULE3] Pins with their skip bit set count as already taken.
// [RULE4] UART transmit sits on pin 0.4 and receive on pin 0.5.
// [RULE5] Management bus and UART each route both of their lines.
// [RULE6] Unassigned pins stay general-purpose port pins.
// [RULE7] SPI slave select is routed only in 4-wire mode.
// [RULE8] Analog pins lose pull-up, output driver and input receiver.
// [RULE9] Input-mode 1 is digital, 0 analog; reset is digital.
// [RULE10] Output-mode bit picks open-drain or push-pull for every pin except the management bus pins.
// [RULE11] Management bus pins are always open-drain.
// [RULE12] Pull-up disable at 0 enables pull-ups on open-drain pins.
// [RULE13] A pin driving low has its pull-up switched off.
// [RULE14] Crossbar disabled leaves pins as inputs, routing ignored.
// [RULE15] All output drivers stay off while the crossbar is disabled.
// [RULE16] Software sets modes, skips, routing, then crossbar enable.
// [RULE17] Software skips pins used outside the crossbar and analog pins.
// [RULE18] Routing register 0 holds six enables; bits 7-6 read zero.
// [RULE19] Routing register 1 holds pull-up, enable, timer, counter bits.
// [RULE20] Port register reads return the pin level.
// [RULE21] Fixed priority, pin assignment computed from current registers.
// [RULE22] A resource with no free pin is left disconnected.
module pcx_crossbar (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [1:0]  slave_select_mode_field,
	input  wire logic [16:0] periph_out,
	input  wire logic [16:0] periph_out_en,
	output logic      [16:0] periph_in,
	input  wire logic [15:0] pin_i,
	output logic      [15:0] pin_o,
	output logic      [15:0] pin_oe,
	output logic      [15:0] pin_pullup
);
	localparam int NP = pcx_pkg::NPIN;
	localparam int NR = pcx_pkg::NRES;
	localparam int FIRST = pcx_pkg::R_SCK;

	logic [7:0]    route0_q;
	logic [7:0]    route1_q;
	logic [NP-1:0] pin_skip_mask_q;
	logic [NP-1:0] pin_input_mode_q;
	logic [NP-1:0] pin_output_mode_q;
	logic [NP-1:0] latch_q;
	logic [7:0]    rdata_q;
	logic          rvalid_q;
	logic [NR-1:0] periph_in_q;

	logic          crossbar_enable_bit;
	logic          pullup_disable_bit;
	logic          uart_route;
	logic [1:0]    counter_array_output_count;
	logic [NR-1:0] req;
	logic [NP-1:0] sel [NR];
	logic [NP-1:0] taken [NR+1];
	logic [NP-1:0] rx_level;
	logic [NR-1:0] periph_in_d;
	logic [7:0]    rdata_d;

	pcx_pad_if pad_bus ();

	assign crossbar_enable_bit = route1_q[pcx_pkg::B_XBAR];
	assign pullup_disable_bit  = route1_q[pcx_pkg::B_PUD];
	assign counter_array_output_count =
		route1_q[pcx_pkg::B_CNT_HI:pcx_pkg::B_CNT_LO];
	// [RULE14] routing gated off
	assign uart_route = route0_q[pcx_pkg::B_UART] & crossbar_enable_bit;

	// Resource enables in priority order
	always_comb
	begin
		req = '0;
		// [RULE5] both lines
		req[pcx_pkg::R_UTX]  = route0_q[pcx_pkg::B_UART];
		req[pcx_pkg::R_URX]  = route0_q[pcx_pkg::B_UART];
		req[pcx_pkg::R_SCK]  = route0_q[pcx_pkg::B_SPI];
		req[pcx_pkg::R_MISO] = route0_q[pcx_pkg::B_SPI];
		req[pcx_pkg::R_MOSI] = route0_q[pcx_pkg::B_SPI];
		// [RULE7] select in 4-wire only
		req[pcx_pkg::R_NSS]  = route0_q[pcx_pkg::B_SPI]
			& slave_select_mode_field[pcx_pkg::B_NSS4];
		// [RULE5] data and clock
		req[pcx_pkg::R_SDA]  = route0_q[pcx_pkg::B_MGMT];
		req[pcx_pkg::R_SCL]  = route0_q[pcx_pkg::B_MGMT];
		req[pcx_pkg::R_CMPS] = route0_q[pcx_pkg::B_CMPS];
		req[pcx_pkg::R_CMPA] = route0_q[pcx_pkg::B_CMPA];
		req[pcx_pkg::R_SYSC] = route0_q[pcx_pkg::B_SYSCK];
		// Counter outputs routed up to the programmed count
		for (int i = 0; i < pcx_pkg::NCEX; i++)
		begin
			req[pcx_pkg::R_CEX0 + i] =
				(32'(counter_array_output_count) > i);
		end
		req[pcx_pkg::R_ECI] = route1_q[pcx_pkg::B_ECI];
		req[pcx_pkg::R_T0]  = route1_q[pcx_pkg::B_T0];
		req[pcx_pkg::R_T1]  = route1_q[pcx_pkg::B_T1];
		// [RULE14] nothing routed while disabled
		if (!crossbar_enable_bit)
		begin
			req = '0;
		end
	end

	// [RULE4] fixed UART pins
	assign sel[pcx_pkg::R_UTX] = uart_route ? pcx_pkg::UTX_PIN : '0;
	assign sel[pcx_pkg::R_URX] = uart_route ? pcx_pkg::URX_PIN : '0;
	// [RULE3] skipped pins start out taken
	assign taken[FIRST] = pin_skip_mask_q | sel[pcx_pkg::R_UTX]
		| sel[pcx_pkg::R_URX];
	assign taken[0] = '0;
	assign taken[1] = '0;

	// Priority chain; each stage sees what earlier ones took
	for (genvar r = FIRST; r < NR; r++)
	begin : g_pick
		// [RULE1] lowest free pin
		// [RULE2] taken pins passed over
		// [RULE22] no free pin, no grant
		pcx_pick #(
			.W (NP)
		) u_pick (
			.req       (req[r]),
			.taken_in  (taken[r]),
			.grant     (sel[r]),
			.taken_out (taken[r+1])
		);
	end

	// [RULE8] analog pins have no digital receiver
	assign rx_level = pin_i & pin_input_mode_q;

	// Per-pin source: the granted resource, else the port latch
	always_comb
	begin
		pad_bus.src_val    = latch_q;
		// [RULE6] unassigned pins are port pins
		pad_bus.src_en     = '1;
		// [RULE10] output mode from register
		pad_bus.open_drain = ~pin_output_mode_q;
		periph_in_d        = '0;
		for (int r = 0; r < NR; r++)
		begin
			periph_in_d[r] = |(sel[r] & rx_level);
			for (int p = 0; p < NP; p++)
			begin
				if (sel[r][p])
				begin
					pad_bus.src_val[p] = periph_out[r];
					pad_bus.src_en[p]  = periph_out_en[r];
					// [RULE11] bus pins open-drain
					if (r == pcx_pkg::R_SDA || r == pcx_pkg::R_SCL)
					begin
						pad_bus.open_drain[p] = 1'b1;
					end
				end
			end
		end
	end

	// [RULE9] input-mode bit, 1 is digital
	assign pad_bus.digital = pin_input_mode_q;
	// [RULE12] global pull-up disable
	assign pad_bus.pud     = pullup_disable_bit;
	// [RULE15] drivers need the crossbar
	assign pad_bus.xbar    = crossbar_enable_bit;

	// [RULE13] pull-up off while driving low
	pcx_pad u_pad (
		.sys_clk    (sys_clk),
		.srst       (srst),
		.cfg        (pad_bus.pad),
		.pin_o      (pin_o),
		.pin_oe     (pin_oe),
		.pin_pullup (pin_pullup)
	);

	// Routing registers
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			route0_q <= pcx_pkg::RST_ROUTE;
			route1_q <= pcx_pkg::RST_ROUTE;
		end
		else if (reg_wr)
		begin
			// [RULE18] six enables kept
			if (reg_addr == pcx_pkg::OFS_ROUTE0)
			begin
				route0_q <= reg_wdata & pcx_pkg::ROUTE0_MASK;
			end
			// [RULE19] second routing register
			if (reg_addr == pcx_pkg::OFS_ROUTE1)
			begin
				route1_q <= reg_wdata & pcx_pkg::ROUTE1_MASK;
			end
		end
	end

	// Pin mode and skip registers
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			pin_skip_mask_q   <= {2{pcx_pkg::RST_SKIP}};
			// [RULE9] all pins digital after reset
			pin_input_mode_q  <= {2{pcx_pkg::RST_MDIN}};
			pin_output_mode_q <= {2{pcx_pkg::RST_MDOUT}};
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				pcx_pkg::OFS_SKIP0:  pin_skip_mask_q[7:0]    <= reg_wdata;
				pcx_pkg::OFS_SKIP1:  pin_skip_mask_q[15:8]   <= reg_wdata;
				pcx_pkg::OFS_MDIN0:  pin_input_mode_q[7:0]   <= reg_wdata;
				pcx_pkg::OFS_MDIN1:  pin_input_mode_q[15:8]  <= reg_wdata;
				pcx_pkg::OFS_MDOUT0: pin_output_mode_q[7:0]  <= reg_wdata;
				pcx_pkg::OFS_MDOUT1: pin_output_mode_q[15:8] <= reg_wdata;
				default:             ;
			endcase
		end
	end

	// Port output latches; writes land here, reads see the pins
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			latch_q <= {2{pcx_pkg::RST_LATCH}};
		end
		else if (reg_wr)
		begin
			if (reg_addr == pcx_pkg::OFS_PORT0)
			begin
				latch_q[7:0] <= reg_wdata;
			end
			if (reg_addr == pcx_pkg::OFS_PORT1)
			begin
				latch_q[15:8] <= reg_wdata;
			end
		end
	end

	// Read multiplexer; unmapped addresses read zero
	always_comb
	begin
		case (reg_addr)
			// [RULE20] pin level, not latch
			pcx_pkg::OFS_PORT0:  rdata_d = rx_level[7:0];
			pcx_pkg::OFS_PORT1:  rdata_d = rx_level[15:8];
			// [RULE18] bits 7-6 read zero
			pcx_pkg::OFS_ROUTE0: rdata_d = route0_q;
			pcx_pkg::OFS_ROUTE1: rdata_d = route1_q;
			pcx_pkg::OFS_SKIP0:  rdata_d = pin_skip_mask_q[7:0];
			pcx_pkg::OFS_SKIP1:  rdata_d = pin_skip_mask_q[15:8];
			pcx_pkg::OFS_MDIN0:  rdata_d = pin_input_mode_q[7:0];
			pcx_pkg::OFS_MDIN1:  rdata_d = pin_input_mode_q[15:8];
			pcx_pkg::OFS_MDOUT0: rdata_d = pin_output_mode_q[7:0];
			pcx_pkg::OFS_MDOUT1: rdata_d = pin_output_mode_q[15:8];
			default:             rdata_d = pcx_pkg::RD_NONE;
		endcase
	end

	// Read data held for exactly the cycle after the strobe
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			rdata_q  <= pcx_pkg::RD_NONE;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rdata_q  <= rdata_d;
			rvalid_q <= reg_rd;
		end
	end

	assign reg_rdata = rvalid_q ? rdata_q : pcx_pkg::RD_NONE;

	// Pin levels back to the peripherals; unrouted inputs read low
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			periph_in_q <= '0;
		end
		else
		begin
			periph_in_q <= periph_in_d;
		end
	end

	assign periph_in = periph_in_q;
endmodule : pcx_crossbar
`default_nettype wire

//--- core/pcx_pkg.sv
`default_nettype none
package pcx_pkg;
	// Pin and resource counts
	localparam int NPIN = 16;
	localparam int NRES = 17;

	// Register offsets
	localparam logic [7:0] OFS_PORT0  = 8'h80;
	localparam logic [7:0] OFS_PORT1  = 8'h90;
	localparam logic [7:0] OFS_ROUTE0 = 8'hE1;
	localparam logic [7:0] OFS_ROUTE1 = 8'hE2;
	localparam logic [7:0] OFS_SKIP0  = 8'hD4;
	localparam logic [7:0] OFS_SKIP1  = 8'hD5;
	localparam logic [7:0] OFS_MDIN0  = 8'hF1;
	localparam logic [7:0] OFS_MDIN1  = 8'hF2;
	localparam logic [7:0] OFS_MDOUT0 = 8'hA4;
	localparam logic [7:0] OFS_MDOUT1 = 8'hA5;

	// Reset values
	localparam logic [7:0] RST_ROUTE = 8'h00;
	localparam logic [7:0] RST_SKIP  = 8'h00;
	localparam logic [7:0] RST_MDIN  = 8'hFF;
	localparam logic [7:0] RST_MDOUT = 8'h00;
	localparam logic [7:0] RST_LATCH = 8'hFF;
	localparam logic [7:0] RD_NONE   = 8'h00;

	// Readable bits of the two routing registers
	localparam logic [7:0] ROUTE0_MASK = 8'h3F;
	localparam logic [7:0] ROUTE1_MASK = 8'hFB;

	// Routing register 0 fields
	localparam int B_UART  = 0;
	localparam int B_SPI   = 1;
	localparam int B_MGMT  = 2;
	localparam int B_SYSCK = 3;
	localparam int B_CMPS  = 4;
	localparam int B_CMPA  = 5;
	// Routing register 1 fields
	localparam int B_CNT_LO = 0;
	localparam int B_CNT_HI = 1;
	localparam int B_ECI    = 3;
	localparam int B_T0     = 4;
	localparam int B_T1     = 5;
	localparam int B_XBAR   = 6;
	localparam int B_PUD    = 7;
	// Slave-select mode bit that selects 4-wire
	localparam int B_NSS4   = 1;

	// Resource signals, highest priority first
	localparam int R_UTX  = 0;
	localparam int R_URX  = 1;
	localparam int R_SCK  = 2;
	localparam int R_MISO = 3;
	localparam int R_MOSI = 4;
	localparam int R_NSS  = 5;
	localparam int R_SDA  = 6;
	localparam int R_SCL  = 7;
	localparam int R_CMPS = 8;
	localparam int R_CMPA = 9;
	localparam int R_SYSC = 10;
	localparam int R_CEX0 = 11;
	localparam int R_ECI  = 14;
	localparam int R_T0   = 15;
	localparam int R_T1   = 16;
	localparam int NCEX   = 3;

	// Fixed UART pins
	localparam logic [NPIN-1:0] UTX_PIN = 16'h0010;
	localparam logic [NPIN-1:0] URX_PIN = 16'h0020;
endpackage : pcx_pkg
`default_nettype wire

//--- core/pcx_pad_if.sv
`timescale 1ns/10ps
`default_nettype none
// Per-pin source selection handed from the decoder to the pad cells
interface pcx_pad_if;
	logic [15:0] src_val;
	logic [15:0] src_en;
	logic [15:0] open_drain;
	logic [15:0] digital;
	logic        pud;
	logic        xbar;
	modport dec (output src_val, src_en, open_drain, digital, pud, xbar);
	modport pad (input src_val, src_en, open_drain, digital, pud, xbar);
endinterface : pcx_pad_if
`default_nettype wire

//--- core/pcx_pick.sv
`timescale 1ns/10ps
`default_nettype none
// Grants the lowest free pin to one request and passes the taken mask on
module pcx_pick #(
	parameter int W = 16
) (
	input  wire logic         req,
	input  wire logic [W-1:0] taken_in,
	output logic      [W-1:0] grant,
	output logic      [W-1:0] taken_out
);
	logic [W-1:0] free;

	// Lowest set bit of the free mask; zero when nothing is free
	assign free      = ~taken_in;
	assign grant     = req ? (free & (~free + W'(1))) : '0;
	assign taken_out = taken_in | grant;
endmodule : pcx_pick
`default_nettype wire

//--- core/pcx_pad.sv
`timescale 1ns/10ps
`default_nettype none
// Output driver and weak pull-up control for all crossbar pins
module pcx_pad (
	input  wire logic   sys_clk,
	input  wire logic   srst,
	pcx_pad_if.pad      cfg,
	output logic [15:0] pin_o,
	output logic [15:0] pin_oe,
	output logic [15:0] pin_pullup
);
	logic [15:0] oe_d;
	logic [15:0] low_d;

	// An open-drain pin only drives for a low; no driver while disabled
	assign oe_d  = {16{cfg.xbar}} & cfg.digital & cfg.src_en
		& (~cfg.open_drain | ~cfg.src_val);
	assign low_d = oe_d & ~cfg.src_val;

	// Registered pad outputs
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			pin_o      <= '0;
			pin_oe     <= '0;
			pin_pullup <= '0;
		end
		else
		begin
			pin_o      <= cfg.src_val;
			pin_oe     <= oe_d;
			// Pull-up only on digital open-drain pins not pulled low
			pin_pullup <= cfg.digital & cfg.open_drain & ~low_d
				& {16{~cfg.pud}};
		end
	end
endmodule : pcx_pad
`default_nettype wire

//--- testbench/pcx_crossbar_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Checks crossbar outputs against a shadow of the steering registers
module pcx_crossbar_chk (
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic [16:0] periph_out,
	input wire logic [16:0] periph_out_en,
	input wire logic [16:0] periph_in,
	input wire logic [15:0] pin_i,
	input wire logic [15:0] pin_o,
	input wire logic [15:0] pin_oe,
	input wire logic [15:0] pin_pullup
);
	logic [7:0] r0_q;
	logic [7:0] r1_q;
	logic [7:0] in0_q;

	// Shadow copies, so the checks need no view inside the block
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			r0_q <= 8'h00;
			r1_q <= 8'h00;
			in0_q <= 8'hFF;
		end
		else if (reg_wr)
		begin
			if (reg_addr == 8'hE1)
				r0_q <= reg_wdata;
			if (reg_addr == 8'hE2)
				r1_q <= reg_wdata;
			if (reg_addr == 8'hF1)
				in0_q <= reg_wdata;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence rd_route0;
		reg_rd && reg_addr == 8'hE1;
	endsequence
	sequence rd_route1;
		reg_rd && reg_addr == 8'hE2;
	endsequence
	// Transmit asks for a low level on a live, digital pin
	sequence tx_low;
		r0_q[0] && r1_q[6] && in0_q[4] && periph_out_en[0] && !periph_out[0];
	endsequence

	route0_read_a: assert property (
		rd_route0 |=> reg_rdata[7:6] == 2'b00) else $error("route0 top bits");
	route1_read_a: assert property (
		rd_route1 |=> !reg_rdata[2]) else $error("route1 bit2 set");
	xbar_off_drive_a: assert property (
		!r1_q[6] |=> pin_oe == 16'h0000) else $error("drive while off");
	xbar_off_route_a: assert property (
		!r1_q[6] |=> periph_in == 17'h00000) else $error("route while off");
	pud_pullup_a: assert property (
		r1_q[7] |=> pin_pullup == 16'h0000) else $error("pullup kept");
	low_pullup_a: assert property (
		(pin_oe & ~pin_o & pin_pullup) == 16'h0000) else $error("pullup low");
	tx_pin_a: assert property (
		tx_low |=> pin_oe[4] && !pin_o[4]) else $error("tx pin wrong");
	rx_pin_a: assert property (
		r0_q[0] && r1_q[6] && in0_q[5] |=> periph_in[1] == $past(pin_i[5]))
		else $error("rx pin wrong");
	analog_pin_a: assert property (
		!in0_q[0] |=> !pin_oe[0] && !pin_pullup[0]) else $error("analog pin");
endmodule : pcx_crossbar_chk

bind pcx_crossbar pcx_crossbar_chk u_chk (.sys_clk, .srst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .periph_out, .periph_out_en,
	.periph_in, .pin_i, .pin_o, .pin_oe, .pin_pullup);
`default_nettype wire

//--- testbench/pcx_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
// Peripherals and outside circuits seen from the crossbar
module pcx_periph_model (
	input  wire logic [15:0] pin_o,
	input  wire logic [15:0] pin_oe,
	input  wire logic [15:0] pin_pullup,
	input  wire logic [15:0] ext_lvl,
	input  wire logic        out_hi,
	output logic      [15:0] pin_i,
	output logic      [16:0] periph_out,
	output logic      [16:0] periph_out_en
);
	// Receive, counter clock and timer inputs never ask to drive
	assign periph_out_en = 17'h03FFD;
	assign periph_out = {17{out_hi}};
	// Our driver wins, else the weak pull-up, else the outside circuit
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & (pin_pullup | ext_lvl));
endmodule : pcx_periph_model
`default_nettype wire

//--- testbench/tb_priority_crossbar_port_config.sv
`timescale 1ns/10ps
`default_nettype none
module tb_priority_crossbar_port_config;
	typedef struct packed {
		logic [7:0]  r0;
		logic [7:0]  r1;
		logic [7:0]  sk0;
		logic [7:0]  sk1;
		logic [7:0]  in0;
		logic [7:0]  out0;
		logic [1:0]  nss;
		logic        hi;
		logic [15:0] oe;
		logic [15:0] pu;
	} pcx_case_type;

	// Off, 3-wire, 4-wire with bus, crystal skip, starved, open-drain bus,
	// analog pin, port 1 outputs with pull-ups off
	localparam pcx_case_type CASES [8] = '{
		'{8'h07,8'h00,8'h00,8'h00,8'hFF,8'h00,2'h2,1'h0,16'h0000,16'hFFFF},
		'{8'h03,8'h40,8'h00,8'h00,8'hFF,8'h00,2'h0,1'h0,16'h0017,16'hFFE8},
		'{8'h07,8'h40,8'h00,8'h00,8'hFF,8'h00,2'h2,1'h0,16'h00DF,16'hFF20},
		'{8'h03,8'h40,8'h0C,8'h00,8'hFF,8'h00,2'h0,1'h0,16'h0053,16'hFFAC},
		'{8'h07,8'h43,8'hCF,8'hFE,8'hFF,8'h00,2'h2,1'h0,16'h0110,16'hFEEF},
		'{8'h04,8'h40,8'h00,8'h00,8'hFF,8'hFF,2'h0,1'h1,16'h00FC,16'hFF03},
		'{8'h03,8'h40,8'h01,8'h00,8'hFE,8'h01,2'h0,1'h0,16'h001E,16'hFFE0},
		'{8'h38,8'hFA,8'hFF,8'h00,8'hFF,8'h00,2'h0,1'h0,16'h1F00,16'h0000}
	};
	localparam logic [7:0] RA [9] = '{8'hE1, 8'hE2, 8'hD4, 8'hD5, 8'hF1,
		8'hF2, 8'hA4, 8'hA5, 8'h00};
	localparam logic [7:0] RV [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
		8'hFF, 8'h00, 8'h00, 8'h00};

	logic        sys_clk;
	logic        srst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic [1:0]  slave_select_mode_field = 2'h0;
	logic [16:0] periph_out;
	logic [16:0] periph_out_en;
	logic [16:0] periph_in;
	logic [15:0] pin_i;
	logic [15:0] pin_o;
	logic [15:0] pin_oe;
	logic [15:0] pin_pullup;
	logic [15:0] ext_lvl = 16'hA5C3;
	logic        out_hi = 1'b0;
	logic [7:0]  rd_val;
	int          bad_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	pcx_crossbar u_dut (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .slave_select_mode_field, .periph_out,
		.periph_out_en, .periph_in, .pin_i, .pin_o, .pin_oe, .pin_pullup);
	pcx_periph_model u_far (.pin_o, .pin_oe, .pin_pullup, .ext_lvl, .out_hi,
		.pin_i, .periph_out, .periph_out_en);

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task check(input logic [16:0] seen, input logic [16:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : rd

	// Crossbar goes off first so no half-built routing ever drives a pin
	task run_case(input pcx_case_type c);
		wr(8'hE2, 8'h00);
		wr(8'hF1, c.in0);
		wr(8'hA4, c.out0);
		wr(8'hD4, c.sk0);
		wr(8'hD5, c.sk1);
		wr(8'hE1, c.r0);
		slave_select_mode_field <= c.nss;
		out_hi <= c.hi;
		wr(8'hE2, c.r1);
		@(posedge sys_clk);
		#1;
		check(17'(pin_oe), 17'(c.oe));
		check(17'(pin_oe[7:0]), 17'(c.oe[7:0]));
		check(17'(pin_oe[15:8]), 17'(c.oe[15:8]));
		check(17'(pin_pullup), 17'(c.pu));
	endtask : run_case

	task complete_run;
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	// Cut a hang short; the whole run needs under two hundred cycles
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			bad_count++;
			complete_run();
		end
	end

	initial
	begin
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		// Reset values, an unmapped address among them
		for (int i = 0; i < 9; i++)
		begin
			rd(RA[i]);
			check(17'(rd_val), 17'(RV[i]));
		end
		wr(8'hE1, 8'hFF);
		rd(8'hE1);
		check(17'(rd_val), 17'h0003F);
		wr(8'hE2, 8'hFF);
		rd(8'hE2);
		check(17'(rd_val), 17'h000FB);
		$display("register test done");
		for (int i = 0; i < 8; i++)
		begin
			run_case(CASES[i]);
			$display("routing test %0d done", i);
		end
		// Port reads and routed inputs follow the pin levels
		rd(8'h80);
		check(17'(rd_val), 17'h000C3);
		rd(8'h90);
		check(17'(rd_val), 17'h000A0);
		check(17'(periph_in[16:14]), 17'h00005);
		$display("port read test done");
		complete_run();
	end
endmodule : tb_priority_crossbar_port_config
`default_nettype wire
